// >>> design/frs_defs.svh
// Operation
// - unipolar source: use magnitude, no direction
// - bipolar source: sign gives direction, others ignored
// - bipolar halves map linearly to zero..highest
// - mode 6: reference from serial host value
// - main any channel, auxiliary only two/three
// - seven ranges channels one/three, six channel two
// - range fixes span, slope, dead zone
// - mode 7: serial plus analog magnitude
// - mode 8: stored digital plus analog magnitude
// - mode 8 keys trim digital part only
// - stored digital rewrite updates digital part
// - power failure saves digital part to stored
// - mode 9: frequency from terminal eight pulses
// - entering mode 9 clears terminal eight function
// - full-scale pulse rate maps to highest frequency
// - up/down adjustment added in listed modes
// - up/down limited, changes only while running
// - up/down kept over stop, cleared on command
// - analog plus auxiliary, clamped to limits
// - auxiliary gives bipolar percent-of-highest adjustment
// - special running modes ignore setting mode
// - keypad reconnect while running reloads stored digital setting (modes 0/1/8)
// - power-on loads stored digital frequency
// - auxiliary span configurable, low/mid/high mapping
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH

`define FRS_ADDR_MODE 8'h00
`define FRS_ADDR_RANGE 8'h04
`define FRS_ADDR_STORED 8'h08
`define FRS_ADDR_SERIAL 8'h0c
`define FRS_ADDR_FMAX 8'h10
`define FRS_ADDR_LOW 8'h14
`define FRS_ADDR_PULSE_FS 8'h18
`define FRS_ADDR_TERM8 8'h1c
`define FRS_ADDR_STATUS 8'h20
`define FRS_ADDR_UPDOWN 8'h24
`define FRS_ADDR_DIGITAL 8'h28

`define FRS_MODE_RST 4'h0
`define FRS_MAIN_RST 2'h0
`define FRS_AUX_RST 2'h0
`define FRS_RANGE_RST 3'h1
`define FRS_STORED_RST 16'h1388
`define FRS_FMAX_RST 16'h1388
`define FRS_HIGH_RST 16'h1388
`define FRS_LOW_RST 16'h0000
`define FRS_SPAN_RST 8'h0a
`define FRS_PULSE_FS_RST 16'hc350
`define FRS_TERM8_RST 8'h00

`define FRS_AUX_SEL_CH2 2'h1
`define FRS_AUX_SEL_CH3 2'h2
`define FRS_RANGE_BIPOLAR 3'h7
`define FRS_FULL 11'h7ff
`define FRS_MID 40'sd1024
`define FRS_DEAD 11'h199
`define FRS_AUX_DIV 40'sd102400
`define FRS_STEP 16'h0001

`define FRS_CLK_PERIOD_NS 10
`define FRS_GATE_MS 10
`define FRS_GATE_CYCLES (`FRS_GATE_MS * 1000000 / `FRS_CLK_PERIOD_NS)
`define FRS_RATE_MUL (1000 / `FRS_GATE_MS)

`endif

// >>> design/frs_pkg.sv
package frs_pkg;

	typedef enum logic [3:0] {
		MODE_DIGITAL_1 = 4'b0000,
		MODE_DIGITAL_2 = 4'b0001,
		MODE_DIGITAL_3 = 4'b0010,
		MODE_DIGITAL_4 = 4'b0011,
		MODE_TERMINAL = 4'b0100,
		MODE_ANALOG = 4'b0101,
		MODE_SERIAL = 4'b0110,
		MODE_SERIAL_ANALOG = 4'b0111,
		MODE_STORED_ANALOG = 4'b1000,
		MODE_PULSE = 4'b1001
	} frs_mode_e;

	typedef struct packed {
		logic signed [11:0] ch3;
		logic signed [11:0] ch2;
		logic signed [11:0] ch1;
	} frs_ana_s;

	typedef struct packed {
		logic [15:0] fmax;
		logic [15:0] high;
		logic [15:0] low;
	} frs_lim_s;

endpackage

// >>> design/frs_pulse_meter.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_defs.svh"
module frs_pulse_meter #(
	parameter int GATE_CYCLES = `FRS_GATE_CYCLES,
	parameter int RATE_MUL = `FRS_RATE_MUL
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic i_pulse,
	input wire logic [15:0] i_fmax,
	input wire logic [15:0] i_full_scale,
	output logic [15:0] o_freq
);
	localparam int GW = $clog2(GATE_CYCLES + 1);
	logic pulse_q;
	logic [GW-1:0] gate_cnt;
	logic [15:0] edge_cnt;
	logic gate_end;
	logic [47:0] rate_prod;
	logic [47:0] scaled;

	assign gate_end = (gate_cnt == GW'(GATE_CYCLES - 1));
	// measured rate in Hz times highest frequency
	assign rate_prod = 48'(edge_cnt) * 48'(RATE_MUL) * 48'(i_fmax);
	assign scaled = (i_full_scale == 16'h0000) ? 48'(i_fmax) :
		rate_prod / 48'(i_full_scale);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b || !i_enable) begin
			pulse_q <= 1'b0;
			gate_cnt <= '0;
			edge_cnt <= 16'h0000;
		end else begin
			pulse_q <= i_pulse;
			gate_cnt <= gate_end ? '0 : gate_cnt + GW'(1);
			if (gate_end) begin
				edge_cnt <= 16'(i_pulse && !pulse_q);
			end else if (i_pulse && !pulse_q && edge_cnt != 16'hffff) begin
				edge_cnt <= edge_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_freq <= 16'h0000;
		end else if (gate_end) begin
			// saturate at highest frequency
			o_freq <= (scaled > 48'(i_fmax)) ? i_fmax : scaled[15:0];
		end
	end
endmodule
`default_nettype wire

// >>> design/frs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_defs.svh"
module frs_top #(
	parameter int GATE_CYCLES = `FRS_GATE_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire frs_pkg::frs_ana_s i_ana,
	input wire logic i_digital_terminal_eight,
	input wire logic i_running,
	input wire logic i_special_run,
	input wire logic i_power_fail,
	input wire logic i_key_up,
	input wire logic i_key_dn,
	input wire logic i_keypad_present,
	input wire logic i_ud_up,
	input wire logic i_ud_dn,
	input wire logic i_ud_clear,
	output logic [15:0] o_freq_ref,
	output logic o_reverse_rotation,
	output logic o_dir_forced,
	output logic o_term8_func_enable,
	output logic o_mode_ignored
);
	logic [3:0] mode;
	logic [3:0] prev_mode;
	logic [1:0] main_sel;
	logic [1:0] aux_sel;
	logic [2:0] rng1;
	logic [2:0] rng2;
	logic [2:0] rng3;
	logic [15:0] stored_digital_frequency;
	logic [15:0] serial_freq;
	logic [15:0] pulse_full_scale_frequency;
	logic [7:0] terminal_eight_function_select;
	logic [7:0] aux_span;
	frs_pkg::frs_lim_s lim;
	logic [15:0] dig_part;
	logic [15:0] ud_adj;
	logic keypad_q;
	logic pfail_q;
	logic [15:0] pulse_freq;

	logic wr_mode;
	logic wr_stored;
	logic stored_mode;
	logic mode9_entry;
	logic keypad_back;
	logic pfail_edge;

	logic signed [11:0] main_smp;
	logic signed [11:0] aux_smp;
	logic [2:0] main_rng;
	logic [2:0] aux_rng;
	logic [11:0] main_nv;
	logic [11:0] aux_nv;
	logic [15:0] main_f;
	logic aux_on;
	logic signed [39:0] aux_prod;
	logic signed [19:0] aux_adj;
	logic signed [19:0] base;
	logic signed [19:0] sum;
	logic ud_mode;
	logic [15:0] next_freq;
	logic next_reverse;
	logic next_forced;

	// returns {reverse sign, normalised level 0..full}
	function automatic logic [11:0] ana_norm(
		input logic signed [11:0] s,
		input logic [2:0] rng,
		input logic is_ch2
	);
		logic [10:0] u;
		logic [10:0] dbl;
		logic [10:0] dz;
		logic [12:0] dz_w;
		logic [10:0] n;
		logic neg;
		u = 11'h000;
		dbl = 11'h000;
		dz = 11'h000;
		dz_w = 13'h0000;
		n = 11'h000;
		neg = 1'b0;
		// magnitude of a negative level
		if (s[11]) begin
			u = (s == -12'sd2048) ? `FRS_FULL : 11'(-s);
		end else begin
			u = s[10:0];
		end
		dbl = (u[10] == 1'b1) ? `FRS_FULL : {u[9:0], 1'b0};
		if (u >= `FRS_DEAD) begin
			dz_w = 13'((13'(u) - 13'(`FRS_DEAD)) * 13'h0005);
			dz = 11'(dz_w >> 2);
		end
		case (rng)
			3'h1: n = u;
			3'h2: n = dbl;
			3'h3: n = `FRS_FULL - u;
			3'h4: n = `FRS_FULL - dbl;
			3'h5: n = dz;
			3'h6: n = (u < `FRS_DEAD) ? 11'h000 : `FRS_FULL - dz;
			3'h7: begin
				// symmetric range absent on the mixed channel
				n = is_ch2 ? 11'h000 : u;
				neg = !is_ch2 && s[11];
			end
			default: n = 11'h000;
		endcase
		return {neg, n};
	endfunction

	function automatic logic [15:0] scale(
		input logic [10:0] n,
		input logic [15:0] fmax
	);
		logic [26:0] prod;
		prod = 27'(n) * 27'(fmax);
		return 16'(prod >> 11);
	endfunction

	frs_pulse_meter #(
		.GATE_CYCLES(GATE_CYCLES),
		.RATE_MUL(`FRS_RATE_MUL)
	) u_pulse (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_enable(mode == frs_pkg::MODE_PULSE),
		.i_pulse(i_digital_terminal_eight),
		.i_fmax(lim.fmax),
		.i_full_scale(pulse_full_scale_frequency),
		.o_freq(pulse_freq)
	);

	assign wr_mode = i_wr && (i_addr == `FRS_ADDR_MODE);
	assign wr_stored = i_wr && (i_addr == `FRS_ADDR_STORED);
	assign stored_mode = (mode == frs_pkg::MODE_DIGITAL_1) ||
		(mode == frs_pkg::MODE_DIGITAL_2) ||
		(mode == frs_pkg::MODE_STORED_ANALOG);
	assign mode9_entry = (mode == frs_pkg::MODE_PULSE) &&
		(prev_mode != frs_pkg::MODE_PULSE);
	assign keypad_back = i_keypad_present && !keypad_q && i_running;
	assign pfail_edge = i_power_fail && !pfail_q;

	// configuration registers
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			mode <= `FRS_MODE_RST;
			main_sel <= `FRS_MAIN_RST;
			aux_sel <= `FRS_AUX_RST;
			rng1 <= `FRS_RANGE_RST;
			rng2 <= `FRS_RANGE_RST;
			rng3 <= `FRS_RANGE_RST;
			serial_freq <= 16'h0000;
			lim.fmax <= `FRS_FMAX_RST;
			lim.high <= `FRS_HIGH_RST;
			lim.low <= `FRS_LOW_RST;
			aux_span <= `FRS_SPAN_RST;
			pulse_full_scale_frequency <= `FRS_PULSE_FS_RST;
		end else if (i_wr) begin
			if (i_addr == `FRS_ADDR_MODE) begin
				mode <= (i_wdata[3:0] > 4'h9) ? mode : i_wdata[3:0];
				main_sel <= (i_wdata[5:4] == 2'h3) ? main_sel : i_wdata[5:4];
				aux_sel <= i_wdata[7:6];
			end else if (i_addr == `FRS_ADDR_RANGE) begin
				rng1 <= i_wdata[2:0];
				rng2 <= (i_wdata[5:3] == `FRS_RANGE_BIPOLAR) ? rng2 :
					i_wdata[5:3];
				rng3 <= i_wdata[8:6];
			end else if (i_addr == `FRS_ADDR_SERIAL) begin
				serial_freq <= i_wdata[15:0];
			end else if (i_addr == `FRS_ADDR_FMAX) begin
				lim.fmax <= i_wdata[15:0];
				lim.high <= i_wdata[31:16];
			end else if (i_addr == `FRS_ADDR_LOW) begin
				lim.low <= i_wdata[15:0];
				aux_span <= i_wdata[23:16];
			end else if (i_addr == `FRS_ADDR_PULSE_FS) begin
				pulse_full_scale_frequency <= i_wdata[15:0];
			end
		end
	end

	// terminal eight function select, cleared on mode 9 entry
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			prev_mode <= `FRS_MODE_RST;
			terminal_eight_function_select <= `FRS_TERM8_RST;
			o_term8_func_enable <= 1'b1;
		end else begin
			prev_mode <= mode;
			if (mode9_entry) begin
				terminal_eight_function_select <= 8'h00;
			end else if (i_wr && i_addr == `FRS_ADDR_TERM8) begin
				terminal_eight_function_select <= i_wdata[7:0];
			end
			o_term8_func_enable <= (mode != frs_pkg::MODE_PULSE);
		end
	end

	// stored digital frequency and the live digital part
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			stored_digital_frequency <= `FRS_STORED_RST;
			dig_part <= `FRS_STORED_RST;
			keypad_q <= 1'b1;
			pfail_q <= 1'b0;
		end else begin
			keypad_q <= i_keypad_present;
			pfail_q <= i_power_fail;
			// saving on power failure wins over a bus write
			if (pfail_edge) begin
				stored_digital_frequency <= dig_part;
			end else if (wr_stored) begin
				stored_digital_frequency <= i_wdata[15:0];
			end
			if (wr_stored) begin
				dig_part <= i_wdata[15:0];
			end else if (keypad_back && stored_mode) begin
				dig_part <= stored_digital_frequency;
			end else if (stored_mode && i_key_up && dig_part < lim.fmax) begin
				dig_part <= dig_part + `FRS_STEP;
			end else if (stored_mode && i_key_dn && dig_part != 16'h0000) begin
				dig_part <= dig_part - `FRS_STEP;
			end
		end
	end

	// up/down terminal adjustment, kept across stop
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ud_adj <= 16'h0000;
		end else if (i_ud_clear) begin
			ud_adj <= 16'h0000;
		end else if (i_running && i_ud_up && ud_adj < lim.fmax) begin
			ud_adj <= ud_adj + `FRS_STEP;
		end else if (i_running && i_ud_dn && ud_adj != 16'h0000) begin
			ud_adj <= ud_adj - `FRS_STEP;
		end
	end

	// channel selection
	always_comb begin
		main_smp = i_ana.ch1;
		main_rng = rng1;
		if (main_sel == 2'h1) begin
			main_smp = i_ana.ch2;
			main_rng = rng2;
		end else if (main_sel == 2'h2) begin
			main_smp = i_ana.ch3;
			main_rng = rng3;
		end
		aux_smp = i_ana.ch2;
		aux_rng = rng2;
		aux_on = (aux_sel == `FRS_AUX_SEL_CH2);
		if (aux_sel == `FRS_AUX_SEL_CH3) begin
			aux_smp = i_ana.ch3;
			aux_rng = rng3;
			aux_on = 1'b1;
		end
	end

	assign main_nv = ana_norm(main_smp, main_rng, main_sel == 2'h1);
	assign aux_nv = ana_norm(aux_smp, aux_rng, aux_sel == `FRS_AUX_SEL_CH2);
	assign main_f = scale(main_nv[10:0], lim.fmax);
	// low/mid/high of auxiliary level -> -span/0/+span percent
	assign aux_prod = (40'($signed({1'b0, aux_nv[10:0]})) - `FRS_MID) *
		40'($signed({1'b0, aux_span})) *
		40'($signed({1'b0, lim.fmax}));
	assign aux_adj = 20'(aux_prod / `FRS_AUX_DIV);

	// main setting per mode
	always_comb begin
		base = 20'sd0;
		ud_mode = 1'b0;
		next_reverse = 1'b0;
		next_forced = 1'b0;
		case (frs_pkg::frs_mode_e'(mode))
			frs_pkg::MODE_DIGITAL_1, frs_pkg::MODE_DIGITAL_2,
			frs_pkg::MODE_DIGITAL_3, frs_pkg::MODE_DIGITAL_4: begin
				base = 20'(dig_part);
				ud_mode = 1'b1;
			end
			frs_pkg::MODE_TERMINAL: begin
				base = 20'(dig_part);
			end
			frs_pkg::MODE_ANALOG: begin
				base = 20'(main_f) + (aux_on ? aux_adj : 20'sd0);
				ud_mode = 1'b1;
				next_forced = (main_rng == `FRS_RANGE_BIPOLAR) &&
					(main_sel != 2'h1);
				next_reverse = main_nv[11];
			end
			frs_pkg::MODE_SERIAL: begin
				base = 20'(serial_freq);
				ud_mode = 1'b1;
			end
			frs_pkg::MODE_SERIAL_ANALOG: begin
				base = 20'(serial_freq) + 20'(main_f);
			end
			frs_pkg::MODE_STORED_ANALOG: begin
				base = 20'(dig_part) + 20'(main_f);
			end
			frs_pkg::MODE_PULSE: begin
				base = 20'(pulse_freq);
				ud_mode = 1'b1;
			end
			default: begin
				base = 20'sd0;
			end
		endcase
		sum = base + (ud_mode ? 20'(ud_adj) : 20'sd0);
		// signed compare so a negative trimmed sum clamps to the low limit
		if (sum < $signed({4'h0, lim.low})) begin
			next_freq = lim.low;
		end else if (sum > $signed({4'h0, lim.high})) begin
			next_freq = lim.high;
		end else begin
			next_freq = sum[15:0];
		end
	end

	// present reference, frozen while a special running mode owns speed
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_freq_ref <= `FRS_STORED_RST;
			o_reverse_rotation <= 1'b0;
			o_dir_forced <= 1'b0;
			o_mode_ignored <= 1'b0;
		end else begin
			o_mode_ignored <= i_special_run;
			if (!i_special_run) begin
				o_freq_ref <= next_freq;
				o_reverse_rotation <= next_reverse;
				o_dir_forced <= next_forced;
			end
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b || !i_rd) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_addr == `FRS_ADDR_MODE) begin
			o_rdata <= {24'h000000, aux_sel, main_sel, mode};
		end else if (i_addr == `FRS_ADDR_RANGE) begin
			o_rdata <= {23'h000000, rng3, rng2, rng1};
		end else if (i_addr == `FRS_ADDR_STORED) begin
			o_rdata <= {16'h0000, stored_digital_frequency};
		end else if (i_addr == `FRS_ADDR_SERIAL) begin
			o_rdata <= {16'h0000, serial_freq};
		end else if (i_addr == `FRS_ADDR_FMAX) begin
			o_rdata <= {lim.high, lim.fmax};
		end else if (i_addr == `FRS_ADDR_LOW) begin
			o_rdata <= {8'h00, aux_span, lim.low};
		end else if (i_addr == `FRS_ADDR_PULSE_FS) begin
			o_rdata <= {16'h0000, pulse_full_scale_frequency};
		end else if (i_addr == `FRS_ADDR_TERM8) begin
			o_rdata <= {24'h000000, terminal_eight_function_select};
		end else if (i_addr == `FRS_ADDR_STATUS) begin
			o_rdata <= {12'h000, o_term8_func_enable, o_mode_ignored,
				o_dir_forced, o_reverse_rotation, o_freq_ref};
		end else if (i_addr == `FRS_ADDR_UPDOWN) begin
			o_rdata <= {16'h0000, ud_adj};
		end else if (i_addr == `FRS_ADDR_DIGITAL) begin
			o_rdata <= {16'h0000, dig_part};
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// >>> dv/frs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module frs_chk #(
	parameter int GATE_CYCLES = 1000
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_special_run,
	input wire logic [15:0] o_freq_ref,
	input wire logic o_reverse_rotation,
	input wire logic o_dir_forced,
	input wire logic o_term8_func_enable,
	input wire logic o_mode_ignored
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic [3:0] mode;
	logic [1:0] msel;
	logic [8:0] rng;
	logic [15:0] ser;
	logic [15:0] high;
	logic [15:0] low;
	logic bip;
	// shadow of the setting registers, refused writes skipped
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			mode <= 4'h0;
			msel <= 2'h0;
			rng <= 9'h049;
			ser <= 16'h0000;
			high <= 16'h1388;
			low <= 16'h0000;
		end else if (i_wr) begin
			if (i_addr == 8'h00 && i_wdata[3:0] <= 4'h9) mode <= i_wdata[3:0];
			if (i_addr == 8'h00 && i_wdata[5:4] != 2'h3) msel <= i_wdata[5:4];
			if (i_addr == 8'h04) rng[2:0] <= i_wdata[2:0];
			if (i_addr == 8'h04 && i_wdata[5:3] != 3'h7) rng[5:3] <= i_wdata[5:3];
			if (i_addr == 8'h04) rng[8:6] <= i_wdata[8:6];
			if (i_addr == 8'h0c) ser <= i_wdata[15:0];
			if (i_addr == 8'h10) high <= i_wdata[31:16];
			if (i_addr == 8'h14) low <= i_wdata[15:0];
		end
	end
	// main channel on the symmetric bipolar range in analog mode
	assign bip = mode == 4'h5 && rng[msel * 3 +: 3] == 3'h7;
	a_ignored_echo: assert property (
		$past(i_rst_b) |-> o_mode_ignored == $past(i_special_run))
		else $error("ignored flag does not follow special run");
	a_ref_frozen: assert property (
		i_special_run && $past(i_special_run) |=>
		$stable(o_freq_ref) && $stable(o_reverse_rotation))
		else $error("reference moved during special run");
	a_ref_in_limits: assert property (
		!$past(i_wr) && !$past(i_special_run) |->
		o_freq_ref >= low && o_freq_ref <= high)
		else $error("reference outside low and high limits");
	a_reverse_bipolar: assert property (
		o_reverse_rotation && !$past(i_special_run) |-> $past(bip))
		else $error("reverse without bipolar analog source");
	a_dir_forced_src: assert property (
		!$past(i_special_run) |-> o_dir_forced == $past(bip))
		else $error("forced direction flag wrong");
	a_reverse_forced: assert property (
		o_reverse_rotation |-> o_dir_forced)
		else $error("reverse shown without forced direction");
	a_term8_mode: assert property (
		$stable(mode) |-> o_term8_func_enable == (mode != 4'h9))
		else $error("terminal eight function enable wrong");
	a_serial_floor: assert property (
		mode == 4'h6 && !$past(i_wr) && !$past(i_special_run) &&
		ser >= low && ser <= high |-> o_freq_ref >= ser)
		else $error("serial reference not applied");
endmodule
`default_nettype wire

// >>> dv/frs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module frs_src_model (
	input wire logic i_sys_clk,
	input wire logic [15:0] i_period,
	output logic o_pulse
);
	logic [15:0] cnt = 16'h0;
	// square wave on terminal eight, stands low when period is zero
	always @(posedge i_sys_clk) begin
		if (i_period == 16'h0) begin
			cnt <= 16'h0;
			o_pulse <= 1'b0;
		end else begin
			cnt <= (cnt + 16'h1 >= i_period) ? 16'h0 : cnt + 16'h1;
			o_pulse <= cnt < (i_period >> 1);
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_frequency_reference_selector.sv
`timescale 1ns/1ps
`default_nettype none
module tb_frequency_reference_selector;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
	logic spec = 1'b0, pfail = 1'b0, kpres = 1'b1, udc = 1'b0;
	logic rd_seen = 1'b0;
	logic term8;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] e;
	logic [3:0] pls = 4'h0;
	logic [15:0] period = 16'h0;
	frs_pkg::frs_ana_s ana = '0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0] adr_q[$];
	int error_cnt = 0;
	int check_count = 0;
	int s;
	int v;
	localparam logic [7:0] RA[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
		8'h14, 8'h18, 8'h1c, 8'h24, 8'h28, 8'h20, 8'h30};
	localparam logic [31:0] RV[12] = '{32'h0, 32'h49, 32'h1388, 32'h0,
		32'h13881388, 32'h000a0000, 32'hc350, 32'h0, 32'h0, 32'h1388,
		32'h81388, 32'h0};

	frs_top #(.GATE_CYCLES(1000)) dut (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ana(ana),
		.i_digital_terminal_eight(term8), .i_running(run),
		.i_special_run(spec), .i_power_fail(pfail), .i_key_up(pls[3]),
		.i_key_dn(pls[2]), .i_keypad_present(kpres), .i_ud_up(pls[1]),
		.i_ud_dn(pls[0]), .i_ud_clear(udc), .o_freq_ref(),
		.o_reverse_rotation(), .o_dir_forced(), .o_term8_func_enable(),
		.o_mode_ignored());
	frs_src_model src (.i_sys_clk(clk), .i_period(period), .o_pulse(term8));

	initial forever #5 clk = ~clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		cyc(3);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m);
		exp_q.push_back(x & m);
		msk_q.push_back(m);
		adr_q.push_back(a);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		cyc(1);
	endtask
	task automatic tick(input logic [3:0] p);
		pls <= p;
		cyc(1);
		pls <= 4'h0;
		cyc(1);
	endtask
	task automatic cmp(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] y);
		check_count++;
		if (y !== x) begin
			error_cnt++;
			$display("CHECK FAILED reg %h expected %h seen %h", a, x, y);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic int lvl(input int x, input int r);
		int u;
		int d;
		u = x < 0 ? -x : x;
		d = u < 409 ? 0 : ((u - 409) * 5) >> 2;
		case (r)
			1, 7: return u;
			2: return u > 1023 ? 2047 : 2 * u;
			3: return 2047 - u;
			4: return u > 1023 ? 0 : 2047 - 2 * u;
			5: return d;
			default: return u < 409 ? 0 : 2047 - d;
		endcase
	endfunction

	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) cmp(adr_q.pop_front(), exp_q.pop_front(),
			rdata & msk_q.pop_front());
		rd_seen <= rd;
	end

	initial begin
		cyc(20000);
		error_cnt++;
		wrap_up();
	end

	initial begin
		v = $urandom(16);
		cyc(8);
		rst_b <= 1'b1;
		for (int i = 0; i < 12; i++) rchk(RA[i], RV[i], '1);
		wreg(8'h00, 32'h5);
		for (int r = 1; r <= 7; r++) begin
			s = int'($urandom_range(4094)) - 2047;
			if (r == 7) s = -1 - int'($urandom_range(2046));
			ana.ch1 <= 12'(s);
			wreg(8'h04, 32'h48 | 32'(r));
			e = 32'h80000 | (32'(r == 7) << 17) | (32'(r == 7 && s < 0) << 16);
			e = e | 32'((lvl(s, r) * 5000) >> 11);
			rchk(8'h20, e, 32'hfffff);
		end
		wreg(8'h04, 32'h1f9);
		rchk(8'h04, 32'h1c9, '1);
		wreg(8'h04, 32'h49);
		ana.ch1 <= 12'sd1024;
		wreg(8'h00, 32'h45);
		repeat (2) begin
			v = $urandom_range(2047);
			ana.ch2 <= 12'(v);
			cyc(3);
			rchk(8'h20, 2500 + ((v - 1024) * 50000) / 102400, 32'hffff);
		end
		ana.ch1 <= 12'sd0;
		ana.ch2 <= 12'sd0;
		wreg(8'h14, 32'h000a0064);
		rchk(8'h20, 32'h64, 32'hffff);
		wreg(8'h14, 32'h000a0000);
		ana.ch1 <= 12'sd1024;
		ana.ch2 <= 12'sd2047;
		wreg(8'h10, 32'h0a281388);
		rchk(8'h20, 32'ha28, 32'hffff);
		wreg(8'h10, 32'h13881388);
		wreg(8'h00, 32'h6);
		v = $urandom_range(2000);
		wreg(8'h0c, 32'(v));
		rchk(8'h20, v, 32'hffff);
		tick(4'h2);
		rchk(8'h24, 32'h0, '1);
		run <= 1'b1;
		repeat (3) tick(4'h2);
		tick(4'h1);
		run <= 1'b0;
		cyc(3);
		rchk(8'h24, 32'h2, '1);
		rchk(8'h20, v + 2, 32'hffff);
		wreg(8'h08, 32'h64);
		wreg(8'h00, 32'h4);
		rchk(8'h20, 32'h64, 32'hffff);
		wreg(8'h00, 32'h3);
		rchk(8'h20, 32'h66, 32'hffff);
		wreg(8'h04, 32'h4f);
		ana.ch1 <= -12'sd1000;
		wreg(8'h00, 32'h7);
		rchk(8'h20, v + 2441, 32'h1ffff);
		udc <= 1'b1;
		cyc(2);
		udc <= 1'b0;
		rchk(8'h24, 32'h0, '1);
		wreg(8'h04, 32'h49);
		ana.ch1 <= 12'sd409;
		wreg(8'h08, 32'h3e8);
		wreg(8'h00, 32'h8);
		tick(4'h8);
		tick(4'h8);
		rchk(8'h28, 32'h3ea, '1);
		rchk(8'h08, 32'h3e8, '1);
		rchk(8'h20, 32'h7d0, 32'hffff);
		wreg(8'h08, 32'h5dc);
		rchk(8'h28, 32'h5dc, '1);
		tick(4'h4);
		pfail <= 1'b1;
		cyc(2);
		rchk(8'h08, 32'h5db, '1);
		pfail <= 1'b0;
		tick(4'h8);
		run <= 1'b1;
		kpres <= 1'b0;
		cyc(2);
		kpres <= 1'b1;
		cyc(2);
		rchk(8'h28, 32'h5db, '1);
		wreg(8'h00, 32'h6);
		wreg(8'h0c, 32'h12c);
		spec <= 1'b1;
		wreg(8'h0c, 32'h2bc);
		rchk(8'h20, 32'hc012c, 32'hfffff);
		spec <= 1'b0;
		cyc(3);
		rchk(8'h20, 32'h802bc, 32'hfffff);
		wreg(8'h1c, 32'h5);
		wreg(8'h18, 32'h1f40);
		period <= 16'h19;
		wreg(8'h00, 32'h9);
		rchk(8'h1c, 32'h0, '1);
		rchk(8'h20, 32'h0, 32'h80000);
		cyc(3200);
		rchk(8'h20, 32'h9c4, 32'hffff);
		wreg(8'h18, 32'h3e8);
		cyc(2200);
		rchk(8'h20, 32'h1388, 32'hffff);
		period <= 16'h0;
		wreg(8'h00, 32'h0);
		rchk(8'h20, 32'h80000, 32'h80000);
		cyc(4);
		wrap_up();
	end
endmodule

bind frs_top frs_chk #(.GATE_CYCLES(GATE_CYCLES)) u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_special_run(i_special_run),
	.o_freq_ref(o_freq_ref), .o_reverse_rotation(o_reverse_rotation),
	.o_dir_forced(o_dir_forced), .o_term8_func_enable(o_term8_func_enable),
	.o_mode_ignored(o_mode_ignored));
`default_nettype wire
